/* rtl/cfg_field_pkg.sv */
// Purpose: Shared constants and types for the config field bank.
// Assumes: 32-bit AHB-Lite words, one register per aligned word.
// Notes:   Offsets are byte addresses inside a 256-byte window.
`default_nettype none
package cfg_field_pkg;
    // Function role that this bank presents.
    typedef enum logic [1:0] {
        ROLE_RCIEP,
        ROLE_RCEC,
        ROLE_RP,
        ROLE_EP
    } role_t;

    // Register byte offsets.
    localparam logic [7:0] OFF_EXP_CAP  = 8'h00;
    localparam logic [7:0] OFF_DEV_CAP  = 8'h04;
    localparam logic [7:0] OFF_DEV_CTL  = 8'h08;
    localparam logic [7:0] OFF_DEV_CAP2 = 8'h0c;
    localparam logic [7:0] OFF_DEV_CTL2 = 8'h10;
    localparam logic [7:0] OFF_PM_CAP   = 8'h14;
    localparam logic [7:0] OFF_PM_CSR   = 8'h18;
    localparam logic [7:0] OFF_PM_DATA  = 8'h1c;
    localparam logic [7:0] OFF_COMMAND  = 8'h20;
    localparam logic [7:0] OFF_BRG_CTL  = 8'h24;
    localparam logic [7:0] OFF_SLOT_CAP = 8'h28;
    localparam logic [7:0] OFF_SLOT_CTL = 8'h2c;
    localparam logic [7:0] OFF_SLOT_STS = 8'h30;
    localparam logic [7:0] OFF_ROLE     = 8'h34;

    // Device type encodings and capability versions.
    localparam logic [3:0] DT_EP    = 4'h0;
    localparam logic [3:0] DT_RP    = 4'h4;
    localparam logic [3:0] DT_RCIEP = 4'h9;
    localparam logic [3:0] DT_RCEC  = 4'ha;
    localparam logic [3:0] EXP_VER  = 4'h2;
    localparam logic [2:0] PM_VER   = 3'h3;

    // Field positions.
    localparam int EC_DT    = 4;
    localparam int EC_SLOT  = 8;
    localparam int DCP_ETAG = 5;
    localparam int DCP_RBER = 15;
    localparam int DCP_FLR  = 28;
    localparam int DC_RO    = 4;
    localparam int DC_MPS   = 5;
    localparam int DC_ETAG  = 8;
    localparam int DC_NS    = 11;
    localparam int DC_MRRS  = 12;
    localparam int DC2_LTR  = 11;
    localparam int DC2_TPH  = 12;
    localparam int DC2_C10  = 16;
    localparam int DC2_R10  = 17;
    localparam int DC2_EFMT = 20;
    localparam int DC2_FRS  = 31;
    localparam int D2C_IREQ = 8;
    localparam int D2C_ICPL = 9;
    localparam int CMD_MEM  = 1;
    localparam int CMD_BME  = 2;
    localparam int BC_SBR   = 6;
    localparam int SC_DLLE  = 12;
    localparam int SS_PRES  = 6;
    localparam int SS_DLLSC = 8;

    // Reset value of the role register.
    localparam role_t ROLE_RST = ROLE_RCIEP;

    // Bus front-end state.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       bad;
        logic [7:0] ofs;
        logic       ready;
    } front_state_t;

    // Register bank state.
    typedef struct packed {
        logic        pres_s1;
        logic        pres_s2;
        role_t       role;
        logic [3:0]  dc_err;
        logic [2:0]  dc_mps;
        logic [2:0]  dc_mrrs;
        logic        dc_etag;
        logic        dc_ro;
        logic        dc_ns;
        logic        d2_ireq;
        logic        d2_icpl;
        logic [1:0]  pm_state;
        logic        cmd_mem;
        logic        cmd_bme;
        logic        sbr;
        logic        dlle;
        logic        dllsc;
        logic [31:0] hrdata;
        logic        hot_rst;
        logic        mem_req;
        logic        ro_en;
        logic        ns_en;
        logic        ireq_en;
        logic        icpl_en;
    } cfg_state_t;
endpackage
`default_nettype wire

/* rtl/ahb_word_port.sv */
// Purpose: AHB-Lite slave front end for single word transfers.
// Assumes: One slave; hready is this block's own hreadyout.
// Notes:   Writes take no wait, reads one wait state.
`timescale 1ns/1ps
`default_nettype none
module ahb_word_port
(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic        hready_i,
    output logic             wr_o,
    output logic             rd_o,
    output logic             bad_o,
    output logic [7:0]       ofs_o,
    output logic             hreadyout_o
);
    // All front-end state.
    cfg_field_pkg::front_state_t s_reg;
    cfg_field_pkg::front_state_t s_next;
    logic                        take;

    // A transfer is taken when selected, NONSEQ or SEQ, and ready.
    assign take = hsel_i && htrans_i[1] && hready_i;

    // Strobes last one cycle; a read holds ready low for that cycle
    // so the bank can register its answer before the data edge.
    always_comb
    begin
        s_next = s_reg;
        s_next.wr = 1'b0;
        s_next.rd = 1'b0;
        if (s_reg.rd)
        begin
            s_next.ready = 1'b1;
        end
        if (take)
        begin
            s_next.wr = hwrite_i;
            s_next.rd = !hwrite_i;
            s_next.ready = hwrite_i;
            s_next.ofs = {haddr_i[7:2], 2'b00};
            s_next.bad = |haddr_i[31:8];
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_reg <= '{wr: 1'b0, rd: 1'b0, bad: 1'b0, ofs: 8'h00,
                       ready: 1'b1};
        end
        else if (ce_i)
        begin
            s_reg <= s_next;
        end
    end

    assign wr_o = s_reg.wr;
    assign rd_o = s_reg.rd;
    assign bad_o = s_reg.bad;
    assign ofs_o = s_reg.ofs;
    assign hreadyout_o = s_reg.ready;
endmodule // ahb_word_port
`default_nettype wire

/* rtl/cfg_field_bank.sv */
// Purpose: Config field bank for integrated express functions.
// Assumes: Capability inputs come from logic on clock_i.
// Notes:   Role is chosen by software in the role register.
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cfg_field_bank
(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    input  wire logic        ro_capable_i,
    input  wire logic        ireq_capable_i,
    input  wire logic        icpl_capable_i,
    input  wire logic [1:0]  tph_cpl_i,
    input  wire logic        frs_cap_i,
    input  wire logic        ltr_cap_i,
    input  wire logic        peer_frs_i,
    input  wire logic        peer_ltr_i,
    input  wire logic        link_change_i,
    input  wire logic        presence_i,
    input  wire logic        mem_req_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic             hot_reset_o,
    output logic             mem_req_o,
    output logic             ro_en_o,
    output logic             ns_en_o,
    output logic             ireq_en_o,
    output logic             icpl_en_o
);
    // Synchronised reset, released two edges after the pin.
    logic [1:0]               rst_sync;
    logic                     rst_q;
    // Bank state and its next value.
    cfg_field_pkg::cfg_state_t s_reg;
    cfg_field_pkg::cfg_state_t s_next;
    // Strobes from the bus front end.
    logic                     wr;
    logic                     rd;
    logic                     bad;
    logic [7:0]               ofs;
    // Role-derived qualifiers.
    logic                     is_rcec;
    logic                     is_rp;
    logic                     ro_ok;
    logic                     ireq_ok;
    logic                     icpl_ok;
    // Read view of the addressed word.
    logic [31:0]              rword;

    // Reset synchroniser; constants only under the async reset.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_sync <= 2'b00;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_q = rst_sync[1];

    // Bus front end; hsize is unused since only words are carried.
    ahb_word_port u_port
    (
        .clock_i     (clock_i),
        .rst_n_i     (rst_q),
        .ce_i        (ce_i),
        .hsel_i      (hsel_i),
        .haddr_i     (haddr_i),
        .htrans_i    (htrans_i),
        .hwrite_i    (hwrite_i),
        .hready_i    (hready_i),
        .wr_o        (wr),
        .rd_o        (rd),
        .bad_o       (bad),
        .ofs_o       (ofs),
        .hreadyout_o (hreadyout_o)
    );

    assign is_rcec = (s_reg.role == cfg_field_pkg::ROLE_RCEC);
    assign is_rp = (s_reg.role == cfg_field_pkg::ROLE_RP);
    // Enables exist only where the function can use them.
    assign ro_ok = ro_capable_i && !is_rcec && !is_rp;
    assign ireq_ok = ireq_capable_i && !is_rcec;
    assign icpl_ok = icpl_capable_i && !is_rcec;

    // Device type for a role; also used by the checks below.
    function automatic logic [3:0] dev_type(
        input cfg_field_pkg::role_t r);
        unique case (r)
            cfg_field_pkg::ROLE_RCIEP: dev_type = cfg_field_pkg::DT_RCIEP;
            cfg_field_pkg::ROLE_RCEC:  dev_type = cfg_field_pkg::DT_RCEC;
            cfg_field_pkg::ROLE_RP:    dev_type = cfg_field_pkg::DT_RP;
            cfg_field_pkg::ROLE_EP:    dev_type = cfg_field_pkg::DT_EP;
        endcase
    endfunction

    // Read multiplexer. Fixed fields are built here, so no write
    // can ever reach them.
    always_comb
    begin
        rword = 32'h0000_0000;
        unique case (ofs)
            cfg_field_pkg::OFF_EXP_CAP:
            begin
                rword[3:0] = cfg_field_pkg::EXP_VER;
                rword[cfg_field_pkg::EC_DT +: 4] = dev_type(s_reg.role);
                // Slot implemented is left at zero for every role.
                rword[cfg_field_pkg::EC_SLOT] = 1'b0;
            end
            cfg_field_pkg::OFF_DEV_CAP:
            begin
                rword[cfg_field_pkg::DCP_ETAG] = 1'b1;
                rword[cfg_field_pkg::DCP_RBER] = 1'b1;
                rword[cfg_field_pkg::DCP_FLR] = !is_rp;
            end
            cfg_field_pkg::OFF_DEV_CTL:
            begin
                // phantom and aux enables stay zero
                rword[3:0] = s_reg.dc_err;
                // read zero where the role lacks the right
                rword[cfg_field_pkg::DC_RO] = s_reg.dc_ro && ro_ok;
                rword[cfg_field_pkg::DC_MPS +: 3] = s_reg.dc_mps;
                rword[cfg_field_pkg::DC_ETAG] = s_reg.dc_etag;
                rword[cfg_field_pkg::DC_NS] = s_reg.dc_ns && !is_rcec;
                rword[cfg_field_pkg::DC_MRRS +: 3] = s_reg.dc_mrrs;
            end
            cfg_field_pkg::OFF_DEV_CAP2:
            begin
                rword[cfg_field_pkg::DC2_TPH +: 2] =
                    is_rcec ? 2'h0 : tph_cpl_i;
                rword[cfg_field_pkg::DC2_LTR] =
                    ltr_cap_i || (is_rcec && peer_ltr_i);
                rword[cfg_field_pkg::DC2_C10] = 1'b1;
                rword[cfg_field_pkg::DC2_R10] = 1'b1;
                rword[cfg_field_pkg::DC2_EFMT] = 1'b1;
                rword[cfg_field_pkg::DC2_FRS] =
                    frs_cap_i || (is_rcec && peer_frs_i);
            end
            cfg_field_pkg::OFF_DEV_CTL2:
            begin
                rword[cfg_field_pkg::D2C_IREQ] = s_reg.d2_ireq && ireq_ok;
                rword[cfg_field_pkg::D2C_ICPL] = s_reg.d2_icpl && icpl_ok;
            end
            // aux current bits [8:6] left at zero
            cfg_field_pkg::OFF_PM_CAP:
                rword[2:0] = cfg_field_pkg::PM_VER;
            // data select and scale stay zero
            cfg_field_pkg::OFF_PM_CSR:
                rword[1:0] = s_reg.pm_state;
            cfg_field_pkg::OFF_COMMAND:
            begin
                rword[cfg_field_pkg::CMD_MEM] = s_reg.cmd_mem;
                rword[cfg_field_pkg::CMD_BME] = s_reg.cmd_bme;
            end
            cfg_field_pkg::OFF_BRG_CTL:
                rword[cfg_field_pkg::BC_SBR] = s_reg.sbr;
            // only the link-change enable is kept
            cfg_field_pkg::OFF_SLOT_CTL:
                rword[cfg_field_pkg::SC_DLLE] = s_reg.dlle;
            cfg_field_pkg::OFF_SLOT_STS:
            begin
                // link change and presence, rest zero
                rword[cfg_field_pkg::SS_PRES] = s_reg.pres_s2;
                rword[cfg_field_pkg::SS_DLLSC] = s_reg.dllsc;
            end
            cfg_field_pkg::OFF_ROLE:
                rword[1:0] = s_reg.role;
            // power data and slot caps read zero
            default:
                rword = 32'h0000_0000;
        endcase
        if (bad)
        begin
            rword = 32'h0000_0000;
        end
    end

    // Next-state logic for the whole bank.
    always_comb
    begin
        s_next = s_reg;
        // The presence pin passes two flops before use.
        s_next.pres_s1 = presence_i;
        s_next.pres_s2 = s_reg.pres_s1;
        if (rd)
        begin
            s_next.hrdata = rword;
        end
        if (wr && !bad)
        begin
            unique case (ofs)
                cfg_field_pkg::OFF_DEV_CTL:
                begin
                    s_next.dc_err = hwdata_i[3:0];
                    s_next.dc_mps = hwdata_i[cfg_field_pkg::DC_MPS +: 3];
                    s_next.dc_mrrs = hwdata_i[cfg_field_pkg::DC_MRRS +: 3];
                    s_next.dc_etag = hwdata_i[cfg_field_pkg::DC_ETAG];
                    // writable only where marking is possible
                    s_next.dc_ro = hwdata_i[cfg_field_pkg::DC_RO] && ro_ok;
                    // held at zero in the event collector
                    s_next.dc_ns = hwdata_i[cfg_field_pkg::DC_NS] && !is_rcec;
                end
                cfg_field_pkg::OFF_DEV_CTL2:
                begin
                    s_next.d2_ireq = hwdata_i[cfg_field_pkg::D2C_IREQ]
                                     && ireq_ok;
                    s_next.d2_icpl = hwdata_i[cfg_field_pkg::D2C_ICPL]
                                     && icpl_ok;
                end
                cfg_field_pkg::OFF_PM_CSR:
                    s_next.pm_state = hwdata_i[1:0];
                cfg_field_pkg::OFF_COMMAND:
                begin
                    s_next.cmd_mem = hwdata_i[cfg_field_pkg::CMD_MEM];
                    s_next.cmd_bme = hwdata_i[cfg_field_pkg::CMD_BME];
                end
                cfg_field_pkg::OFF_BRG_CTL:
                    s_next.sbr = hwdata_i[cfg_field_pkg::BC_SBR];
                cfg_field_pkg::OFF_SLOT_CTL:
                    s_next.dlle = hwdata_i[cfg_field_pkg::SC_DLLE];
                cfg_field_pkg::OFF_SLOT_STS:
                begin
                    // Write one to clear.
                    if (hwdata_i[cfg_field_pkg::SS_DLLSC])
                    begin
                        s_next.dllsc = 1'b0;
                    end
                end
                cfg_field_pkg::OFF_ROLE:
                    s_next.role = cfg_field_pkg::role_t'(hwdata_i[1:0]);
                default:
                    s_next.role = s_reg.role;
            endcase
        end
        // a new link change wins over a clear
        if (link_change_i)
        begin
            s_next.dllsc = 1'b1;
        end
        // hot reset follows secondary bus reset in the root port role only
        s_next.hot_rst = s_reg.sbr && is_rp;
        // requests pass only with bus mastering on
        s_next.mem_req = mem_req_i && s_reg.cmd_bme;
        // Enables leave again if the role loses the right.
        s_next.ro_en = s_reg.dc_ro && ro_ok;
        s_next.ns_en = s_reg.dc_ns && !is_rcec;
        s_next.ireq_en = s_reg.d2_ireq && ireq_ok;
        s_next.icpl_en = s_reg.d2_icpl && icpl_ok;
    end

    // State register; the clock enable freezes all of it.
    always_ff @(posedge clock_i or negedge rst_q)
    begin
        if (!rst_q)
        begin
            s_reg <= '0;
            s_reg.role <= cfg_field_pkg::ROLE_RST;
        end
        else if (ce_i)
        begin
            s_reg <= s_next;
        end
    end

    // Every output but hresp comes straight from a flop; hresp is tied to OKAY.
    assign hrdata_o = s_reg.hrdata;
    assign hresp_o = 1'b0;
    assign hot_reset_o = s_reg.hot_rst;
    assign mem_req_o = s_reg.mem_req;
    assign ro_en_o = s_reg.ro_en;
    assign ns_en_o = s_reg.ns_en;
    assign ireq_en_o = s_reg.ireq_en;
    assign icpl_en_o = s_reg.icpl_en;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_q || !ce_i);

    // A read strobe followed by its data edge.
    sequence read_of(logic [7:0] o);
        rd && !bad && (ofs == o) ##1 1'b1;
    endsequence

    a_hot_reset_follow: assert property (
        (s_reg.sbr && is_rp) |=> hot_reset_o)
        else $error("hot reset did not follow bus reset");
    a_bme_gate_block: assert property (
        !s_reg.cmd_bme |=> !mem_req_o)
        else $error("request passed with bus master off");
    a_rcec_ro_zero: assert property (
        is_rcec ##1 is_rcec |=> !ro_en_o)
        else $error("relaxed ordering on in collector");
    a_rcec_ns_zero: assert property (
        is_rcec ##1 is_rcec |-> !(rword[cfg_field_pkg::DC_NS]
            && ofs == cfg_field_pkg::OFF_DEV_CTL) ##1 !ns_en_o)
        else $error("no snoop on in collector");
    a_ido_req_gate: assert property (
        (wr && ofs == cfg_field_pkg::OFF_DEV_CTL2 && !ireq_ok)
        |=> !s_reg.d2_ireq)
        else $error("ido request enable set without ability");
    a_slot_cap_zero: assert property (
        read_of(cfg_field_pkg::OFF_SLOT_CAP) |-> hrdata_o == 32'h0)
        else $error("slot capabilities not zero");
    a_pm_data_zero: assert property (
        read_of(cfg_field_pkg::OFF_PM_DATA) |-> hrdata_o == 32'h0)
        else $error("power data register not zero");
    a_dev_type_read: assert property (
        read_of(cfg_field_pkg::OFF_EXP_CAP)
        |-> hrdata_o[7:4] == dev_type($past(s_reg.role)))
        else $error("device type mismatch");
    a_aux_cur_zero: assert property (
        read_of(cfg_field_pkg::OFF_PM_CAP) |-> hrdata_o[8:6] == 3'h0)
        else $error("aux current not zero");
    a_link_set_wins: assert property (
        link_change_i |=> s_reg.dllsc)
        else $error("link change lost");
endmodule // cfg_field_bank
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the config field bank.
// Assumes: Single AHB-Lite master; hready is the bank's hreadyout.
// Notes:   Capability inputs are drawn from an LFSR seeded with 46.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clock_i = 1'b0;   // 100 MHz bench clock.
    logic        rst_n_i = 1'b0;   // Active-low reset.
    logic [1:0]  htrans  = 2'h0;   // Transfer type.
    logic [31:0] haddr   = 32'h0;  // Byte address.
    logic        hwrite  = 1'b0;   // Direction.
    logic [31:0] hwdata  = 32'h0;  // Write data.
    logic [8:0]  caps    = 9'h0;   // Capability pins.
    logic        lc = 1'b0, pres = 1'b0, mreq = 1'b0;
    logic [31:0] hrdata, d;
    logic        rdy, hresp, hot, mem, ro, ns, irq, icp;
    logic [15:0] lf = 16'h002e;    // LFSR state, seed 46.
    int          miscompares = 0;  // Failed comparisons.
    int          cmp_count = 0;    // All comparisons.
    bit          rc, ep;
    logic        ce = 1'b1;        // Clock enable.
    logic        ro_x;             // Expected relaxed ordering enable.
    logic [1:0]  ido_x;            // Expected IDO enables, cpl then req.

    cfg_field_bank dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce),
        .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy),
        .ro_capable_i(caps[8]), .ireq_capable_i(caps[7]),
        .icpl_capable_i(caps[6]), .tph_cpl_i(caps[5:4]),
        .frs_cap_i(caps[3]), .ltr_cap_i(caps[2]), .peer_frs_i(caps[1]),
        .peer_ltr_i(caps[0]), .link_change_i(lc), .presence_i(pres),
        .mem_req_i(mreq), .hrdata_o(hrdata), .hreadyout_o(rdy),
        .hresp_o(hresp), .hot_reset_o(hot), .mem_req_o(mem), .ro_en_o(ro),
        .ns_en_o(ns), .ireq_en_o(irq), .icpl_en_o(icp));

    // Free-running clock, 10 ns period.
    initial forever #5 clock_i = ~clock_i;

    // Galois step of a 16-bit LFSR.
    function automatic logic [15:0] step(input logic [15:0] v);
        step = v[0] ? ((v >> 1) ^ 16'hb400) : (v >> 1);
    endfunction

    // Device type nibble expected for a role.
    function automatic logic [3:0] dtype(input int r);
        dtype = (r == 0) ? 4'h9 : (r == 1) ? 4'ha : (r == 2) ? 4'h4 : 4'h0;
    endfunction

    // Compare and count; a mismatch is reported at once.
    task automatic chk(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    // Wait until hready is seen high at a rising edge.
    task automatic wait_rdy();
        @(negedge clock_i);
        while (rdy !== 1'b1) @(negedge clock_i);
        @(posedge clock_i);
    endtask

    // One single word transfer; read data taken at the final edge.
    task automatic xfer(input bit w, input logic [7:0] a,
                        input logic [31:0] wd);
        @(posedge clock_i);
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        d = hrdata;
    endtask

    // Verdict and end of run.
    task automatic results();
        if (miscompares == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge clock_i);
        miscompares++;
        results();
    end

    initial
    begin
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        // Every role, with fresh random capabilities each time.
        for (int r = 0; r < 4; r++)
        begin
            lf = step(lf);
            caps <= lf[8:0];
            rc = (r == 1);
            ep = (r == 0 || r == 3);
            ro_x = lf[8] & ep;
            ido_x = {lf[6], lf[7]} & {2{!rc}};
            xfer(1, cfg_field_pkg::OFF_ROLE, r);
            xfer(1, cfg_field_pkg::OFF_EXP_CAP, 32'hffffffff);
            xfer(0, cfg_field_pkg::OFF_EXP_CAP, 0);
            chk("expcap", d, {24'h0, dtype(r), 4'h2});
            xfer(0, cfg_field_pkg::OFF_DEV_CAP, 0);
            chk("devcap", d, 32'h8020 | ((r != 2) << 28));
            xfer(0, cfg_field_pkg::OFF_DEV_CTL, 0);
            if (rc) chk("rc_mask", {d[11], d[4]}, 2'b00);
            xfer(1, cfg_field_pkg::OFF_DEV_CTL, {16'h0, lf[15:0] | 16'hffff});
            xfer(0, cfg_field_pkg::OFF_DEV_CTL, 0);
            chk("devctl", {d[11:9], d[4]}, {!rc, 2'b0, ro_x});
            chk("ro_en", ro, ro_x);
            chk("ns_en", ns, !rc);
            xfer(1, cfg_field_pkg::OFF_DEV_CTL2, 32'h300);
            xfer(0, cfg_field_pkg::OFF_DEV_CTL2, 0);
            chk("devctl2", d[9:8], ido_x);
            chk("ido_en", {icp, irq}, ido_x);
            xfer(0, cfg_field_pkg::OFF_DEV_CAP2, 0);
            chk("tag10", {d[20], d[17:16]}, 3'h7);
            chk("tph", d[13:12], rc ? 2'h0 : caps[5:4]);
            chk("frs", d[31] | !(rc & caps[1]), 1);
            chk("ltr", d[11] | !(rc & caps[0]), 1);
            xfer(0, cfg_field_pkg::OFF_PM_CAP, 0);
            chk("aux", d[8:6], 3'h0);
            xfer(1, cfg_field_pkg::OFF_PM_CSR, 32'hffffffff);
            xfer(0, cfg_field_pkg::OFF_PM_CSR, 0);
            chk("pmcsr", d, 32'h3);
            xfer(0, cfg_field_pkg::OFF_PM_DATA, 0);
            chk("pmdata", d, 32'h0);
            xfer(1, cfg_field_pkg::OFF_SLOT_CAP, 32'hffffffff);
            xfer(0, cfg_field_pkg::OFF_SLOT_CAP, 0);
            chk("slotcap", d, 32'h0);
            xfer(1, cfg_field_pkg::OFF_SLOT_CTL, 32'hffffffff);
            xfer(0, cfg_field_pkg::OFF_SLOT_CTL, 0);
            chk("slotctl", d, 32'h1000);
        end
        // Root port: slot status, hot reset and bus master gating.
        xfer(1, cfg_field_pkg::OFF_ROLE, 32'h2);
        pres <= 1'b1;
        lc   <= 1'b1;
        mreq <= 1'b1;
        @(posedge clock_i);
        lc <= 1'b0;
        xfer(1, cfg_field_pkg::OFF_COMMAND, 32'h0);
        xfer(0, cfg_field_pkg::OFF_SLOT_STS, 0);
        chk("slotsts", d, 32'h140);
        chk("mem_off", mem, 1'b0);
        xfer(1, cfg_field_pkg::OFF_SLOT_STS, 32'hffff);
        xfer(0, cfg_field_pkg::OFF_SLOT_STS, 0);
        chk("sts_clr", d, 32'h40);
        xfer(1, cfg_field_pkg::OFF_COMMAND, 32'h4);
        xfer(1, cfg_field_pkg::OFF_BRG_CTL, 32'h40);
        repeat (3) @(negedge clock_i);
        chk("mem_on", mem, 1'b1);
        chk("hot_on", hot, 1'b1);
        // Clock enable low must freeze the gated request output.
        @(posedge clock_i);
        ce   <= 1'b0;
        mreq <= 1'b0;
        repeat (3) @(negedge clock_i);
        chk("ce_hold", mem, 1'b1);
        @(posedge clock_i);
        ce   <= 1'b1;
        repeat (2) @(negedge clock_i);
        chk("ce_free", mem, 1'b0);
        xfer(1, cfg_field_pkg::OFF_BRG_CTL, 32'h0);
        xfer(0, 8'h38, 0);
        chk("unmapped", d, 32'h0);
        chk("hot_off", hot, 1'b0);
        chk("hresp", hresp, 1'b0);
        results();
    end
endmodule // tb_top
`default_nettype wire
